// ### logic/l2pf_defs.vh
// constants for the level-2 prefetch and double linefill block
`ifndef L2PF_DEFS_VH
`define L2PF_DEFS_VH

// register offsets (byte addresses)
`define L2PF_OFS_PF_CTRL 8'h00
`define L2PF_OFS_CFG 8'h04
`define L2PF_OFS_STATUS 8'h08
`define L2PF_OFS_PF_COUNT 8'h0C

// prefetch control register fields
`define L2PF_BIT_DBL_EN 30
`define L2PF_BIT_PF_EN_I 29
`define L2PF_BIT_PF_EN_D 28
`define L2PF_BIT_WRAP_DIS 27
`define L2PF_BIT_INCR_DBL 23
`define L2PF_OFF_MSB 4
`define L2PF_OFF_LSB 0
`define L2PF_PF_CTRL_MASK 32'h7880001F

// configuration register fields
`define L2PF_BIT_EXCL 0

// reset values
`define L2PF_PF_CTRL_RST 32'h00000000
`define L2PF_CFG_RST 1'b0

// bus encodings
`define L2PF_BURST_INCR 2'h1
`define L2PF_BURST_WRAP 2'h2
`define L2PF_LEN_ONE_LINE 4'h3
`define L2PF_LEN_TWO_LINES 4'h7
`define L2PF_SIZE_64BIT 3'h3

// geometry
`define L2PF_LINE_BYTES 32'h00000020
`define L2PF_BEAT_BYTES 6'h08

`endif

// ### logic/l2pf_prefetch_linefill.v
// prefetch and linefill shaping logic of a level-2 cache controller
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ns
`include "l2pf_defs.vh"
// Summary of operation
// - prefetch engine on when bit 29 or 28
// - each cacheable read looks up a later line
// - prefetch offset is control bits 4 to 0
// - target is line plus one plus offset
// - no prefetch across a 4KB boundary
// - default miss fills one line, WRAP len 3
// - double linefill: eight beats, len 7, two lines
// - second line looked up; hit data is discarded
// - bits 27 and 23 only count with bit 30
// - double off: original address, single WRAP fill
// - wrap disable: misaligned read stays single line
// - wrap disable clear: misaligned read realigned, two lines
// - INCR option: upper line goes INCR from line start
// - INCR clear: aligned read is WRAP len 7
// - no double fill for prefetch when exclusive
// - no double fill with second line past 4KB
// - double fill only for WRAP4/INCR4 64-bit reads
// - wrap-read-disable bit resets to zero
module l2pf_prefetch_linefill #(
  parameter ADDR_W = 32,
  parameter DATA_W = 64
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire sp_valid,
  input wire sp_cacheable,
  input wire [ADDR_W-1:0] sp_addr,
  input wire miss_valid,
  output wire miss_ready,
  input wire [ADDR_W-1:0] miss_addr,
  input wire [1:0] miss_burst,
  input wire [3:0] miss_len,
  input wire [2:0] miss_size,
  output wire lookup_valid,
  output wire [ADDR_W-1:0] lookup_addr,
  input wire lookup_done,
  input wire lookup_hit,
  output wire ar_valid,
  input wire ar_ready,
  output reg [ADDR_W-1:0] ar_addr,
  output reg [3:0] ar_len,
  output reg [1:0] ar_burst,
  output wire [2:0] ar_size,
  input wire r_valid,
  output wire r_ready,
  input wire [DATA_W-1:0] r_data,
  input wire r_last,
  output reg fill_valid,
  output reg [ADDR_W-1:0] fill_addr,
  output reg [DATA_W-1:0] fill_data,
  output reg fill_alloc,
  output reg fill_prefetch,
  output reg fill_last
);

  localparam ST_IDLE = 3'd0;
  localparam ST_PF_LOOK = 3'd1;
  localparam ST_ISSUE = 3'd2;
  localparam ST_DATA = 3'd3;

  reg [2:0] state_q, state_d;
  reg [31:0] pf_ctrl_q;
  reg excl_q;
  reg [15:0] pf_count_q;
  reg pf_pend_q;
  reg [ADDR_W-1:0] pf_addr_q;
  reg pf_fill_q;
  reg dbl_q;
  reg [ADDR_W-1:0] first_line_q;
  reg [ADDR_W-1:0] beat_addr_q;
  reg [5:0] wrap_mask_q;
  reg sec_pend_q;
  reg sec_keep_q;
  reg [ADDR_W-1:0] look_addr_q;

  wire pf_en = pf_ctrl_q[`L2PF_BIT_PF_EN_I] | pf_ctrl_q[`L2PF_BIT_PF_EN_D];
  wire [4:0] pf_off = pf_ctrl_q[`L2PF_OFF_MSB:`L2PF_OFF_LSB];
  wire dbl_en = pf_ctrl_q[`L2PF_BIT_DBL_EN];
  wire wrap_dis = dbl_en & pf_ctrl_q[`L2PF_BIT_WRAP_DIS];
  wire incr_dbl = dbl_en & pf_ctrl_q[`L2PF_BIT_INCR_DBL];

  // prefetch target: next line plus offset, in 32-byte lines
  wire [ADDR_W-6:0] pf_line = sp_addr[ADDR_W-1:5] + {{(ADDR_W-10){1'b0}}, pf_off} + 1'b1;
  wire [ADDR_W-1:0] pf_tgt = {pf_line, 5'h00};
  wire pf_cross = pf_tgt[ADDR_W-1:12] != sp_addr[ADDR_W-1:12];

  // the engine holds one pending prefetch; a newer read replaces an unlaunched one
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pf_pend_q <= 1'b0;
      pf_addr_q <= {ADDR_W{1'b0}};
    end
    else if (sp_valid && sp_cacheable && pf_en && !pf_cross)
    begin
      pf_pend_q <= 1'b1;
      pf_addr_q <= pf_tgt;
    end
    else if (state_q == ST_PF_LOOK && lookup_done)
    begin
      pf_pend_q <= 1'b0;
    end
  end

  // linefill shaping for the request about to be issued
  wire take_miss = (state_q == ST_IDLE) && miss_valid;
  wire take_pf = (state_q == ST_PF_LOOK) && lookup_done && !lookup_hit;
  wire [ADDR_W-1:0] req_addr = take_miss ? miss_addr : look_addr_q;
  wire req_is_pf = !take_miss;

  // only four-beat 64-bit wrap or incr demand reads may widen; prefetches always qualify
  reg req_shape_ok;
  always @*
  begin
    req_shape_ok = 1'b1;
    if (take_miss)
    begin
      req_shape_ok = 1'b0;
      if (miss_burst == `L2PF_BURST_WRAP || miss_burst == `L2PF_BURST_INCR)
      begin
        if (miss_len == `L2PF_LEN_ONE_LINE && miss_size == `L2PF_SIZE_64BIT)
          req_shape_ok = 1'b1;
      end
    end
  end

  wire req_excl_block = req_is_pf && excl_q;
  wire req_misaligned = req_addr[4:0] != 5'h00;
  wire req_upper = req_addr[5];
  wire [ADDR_W-1:0] req_line = {req_addr[ADDR_W-1:5], 5'h00};
  wire [ADDR_W-1:0] incr_second = req_line + `L2PF_LINE_BYTES;
  wire incr_cross = incr_second[ADDR_W-1:12] != req_addr[ADDR_W-1:12];

  // incr option: aligned upper-line read, or any upper-line read with wrap disable clear
  reg use_incr;
  always @*
  begin
    use_incr = 1'b0;
    if (incr_dbl && req_upper)
    begin
      if (!req_misaligned)
        use_incr = 1'b1;
      else if (!wrap_dis)
        use_incr = 1'b1;
    end
  end

  reg sh_dbl;
  reg [ADDR_W-1:0] sh_addr;
  reg [1:0] sh_burst;
  reg [3:0] sh_len;

  always @*
  begin
    sh_dbl = 1'b0;
    sh_addr = req_addr;
    sh_burst = `L2PF_BURST_WRAP;
    sh_len = `L2PF_LEN_ONE_LINE;
    if (dbl_en && req_shape_ok && !req_excl_block && !(req_misaligned && wrap_dis))
    begin
      if (use_incr)
      begin
        // a crossing incr fill falls back to one line at the original address
        if (!incr_cross)
        begin
          sh_dbl = 1'b1;
          sh_addr = req_line;
          sh_burst = `L2PF_BURST_INCR;
          sh_len = `L2PF_LEN_TWO_LINES;
        end
      end
      else
      begin
        // wrap inside an aligned 64-byte region can never cross 4KB
        sh_dbl = 1'b1;
        sh_addr = req_line;
        sh_burst = `L2PF_BURST_WRAP;
        sh_len = `L2PF_LEN_TWO_LINES;
      end
    end
  end

  // beat wrap boundary: 64 bytes for double fills, 32 bytes for one line
  wire [5:0] req_wrap_mask = sh_dbl ? 6'h3F : 6'h1F;

  // main sequence
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        // demand misses win over a pending prefetch
        if (miss_valid)
          state_d = ST_ISSUE;
        else if (pf_pend_q)
          state_d = ST_PF_LOOK;
      end
      ST_PF_LOOK:
      begin
        if (lookup_done)
          state_d = lookup_hit ? ST_IDLE : ST_ISSUE;
      end
      ST_ISSUE:
      begin
        // one fill in flight keeps the second-line bookkeeping to one set
        if (ar_ready)
          state_d = ST_DATA;
      end
      ST_DATA:
      begin
        if (r_valid && r_ready && r_last)
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  assign miss_ready = (state_q == ST_IDLE);
  assign ar_valid = (state_q == ST_ISSUE);
  assign ar_size = `L2PF_SIZE_64BIT;

  // second-line lookup shares the tag port with the prefetch lookup
  wire [ADDR_W-1:0] sec_line = {first_line_q[ADDR_W-1:6], ~first_line_q[5], 5'h00};
  wire [ADDR_W-1:0] sec_incr = first_line_q + `L2PF_LINE_BYTES;
  wire [ADDR_W-1:0] sec_addr = (ar_burst == `L2PF_BURST_INCR) ? sec_incr : sec_line;
  wire sec_look = (state_q == ST_DATA) && sec_pend_q;
  assign lookup_valid = (state_q == ST_PF_LOOK) || sec_look;
  assign lookup_addr = sec_look ? sec_addr : look_addr_q;

  // beat line membership; second-line beats stall until their lookup answers
  // stalling instead of buffering keeps the allocate decision per beat
  wire beat_second = beat_addr_q[ADDR_W-1:5] != first_line_q[ADDR_W-1:5];
  assign r_ready = (state_q == ST_DATA) && !(dbl_q && beat_second && sec_pend_q);
  wire beat_take = r_valid && r_ready;
  wire [5:0] beat_low = beat_addr_q[5:0] + `L2PF_BEAT_BYTES;
  wire [5:0] beat_next = (beat_addr_q[5:0] & ~wrap_mask_q) | (beat_low & wrap_mask_q);

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ST_IDLE;
      ar_addr <= {ADDR_W{1'b0}};
      ar_len <= 4'h0;
      ar_burst <= 2'h0;
      pf_fill_q <= 1'b0;
      dbl_q <= 1'b0;
      first_line_q <= {ADDR_W{1'b0}};
      beat_addr_q <= {ADDR_W{1'b0}};
      wrap_mask_q <= 6'h00;
      sec_pend_q <= 1'b0;
      sec_keep_q <= 1'b0;
      look_addr_q <= {ADDR_W{1'b0}};
    end
    else
    begin
      state_q <= state_d;
      if (take_miss || take_pf)
      begin
        ar_addr <= sh_addr;
        ar_len <= sh_len;
        ar_burst <= sh_burst;
        pf_fill_q <= req_is_pf;
        dbl_q <= sh_dbl;
        first_line_q <= {sh_addr[ADDR_W-1:5], 5'h00};
        beat_addr_q <= {sh_addr[ADDR_W-1:3], 3'h0};
        wrap_mask_q <= req_wrap_mask;
        sec_pend_q <= sh_dbl;
        sec_keep_q <= 1'b0;
      end
      // freeze the lookup address so a newer read cannot move it mid-lookup
      if (state_q == ST_IDLE && !miss_valid && pf_pend_q)
        look_addr_q <= pf_addr_q;
      if (sec_look && lookup_done)
      begin
        sec_pend_q <= 1'b0;
        sec_keep_q <= !lookup_hit;
      end
      if (beat_take)
      begin
        // incr bursts carry into bit 6; wrap bursts stay inside their region
        if (ar_burst == `L2PF_BURST_INCR)
          beat_addr_q <= beat_addr_q + {{(ADDR_W-6){1'b0}}, `L2PF_BEAT_BYTES};
        else
          beat_addr_q <= {beat_addr_q[ADDR_W-1:6], beat_next};
      end
    end
  end

  // launched prefetch fills, wraps silently at 16 bits
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      pf_count_q <= 16'h0000;
    else if (take_pf)
      pf_count_q <= pf_count_q + 16'h0001;
  end

  // allocation port, one beat per cycle
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fill_valid <= 1'b0;
      fill_addr <= {ADDR_W{1'b0}};
      fill_data <= {DATA_W{1'b0}};
      fill_alloc <= 1'b0;
      fill_prefetch <= 1'b0;
      fill_last <= 1'b0;
    end
    else
    begin
      fill_valid <= beat_take;
      if (beat_take)
      begin
        fill_addr <= beat_addr_q;
        fill_data <= r_data;
        fill_alloc <= !(dbl_q && beat_second) || sec_keep_q;
        fill_prefetch <= pf_fill_q;
        fill_last <= r_last;
      end
    end
  end

  wire [31:0] status_word = {25'h0000000, sec_keep_q, sec_pend_q, dbl_q, pf_pend_q, state_q};

  // register file
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pf_ctrl_q <= `L2PF_PF_CTRL_RST;
      excl_q <= `L2PF_CFG_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `L2PF_OFS_PF_CTRL)
        // unimplemented control bits read back as zero
        pf_ctrl_q <= reg_wdata & `L2PF_PF_CTRL_MASK;
      if (reg_addr == `L2PF_OFS_CFG)
        excl_q <= reg_wdata[`L2PF_BIT_EXCL];
    end
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `L2PF_OFS_PF_CTRL: reg_rdata <= pf_ctrl_q;
        `L2PF_OFS_CFG: reg_rdata <= {31'h00000000, excl_q};
        `L2PF_OFS_STATUS: reg_rdata <= status_word;
        `L2PF_OFS_PF_COUNT: reg_rdata <= {16'h0000, pf_count_q};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
    else
      // read data stands for one cycle only
      reg_rdata <= 32'h00000000;
  end

endmodule

// ### tb/l2pf_l3_model.sv
// level-3 memory answering linefill bursts
`timescale 1ns/1ns
module l2pf_l3_model (
  input wire clk_sys,
  input wire arst_n,
  input wire slow,
  input wire ar_valid,
  output reg ar_ready,
  input wire [31:0] ar_addr,
  input wire [3:0] ar_len,
  output reg r_valid,
  input wire r_ready,
  output reg [63:0] r_data,
  output reg r_last
);
  reg busy_q;
  reg gap;
  reg [3:0] n_q;
  reg [3:0] len_q;
  reg [31:0] a_q;
  integer seed = 32'h305D;
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {busy_q, gap, ar_ready, r_valid, r_last, n_q, len_q, a_q} <= '0;
      r_data <= 64'h0;
    end
    else
    begin
      gap <= $random(seed) % 2 != 0;
      ar_ready <= ar_valid && !ar_ready && !busy_q && !(slow && gap);
      if (ar_valid && ar_ready)
      begin
        {busy_q, a_q, len_q, n_q} <= {1'b1, ar_addr, ar_len, 4'h0};
      end
      if (!r_valid || r_ready)
      begin
        // released data bus flips to its inverse every cycle, so the stale beat shows again every other cycle
        if (busy_q && !(r_valid && r_last) && !(slow && gap))
        begin
          {r_valid, r_last, n_q} <= {1'b1, n_q == len_q, n_q + 4'h1};
          r_data <= {a_q, 28'h0, n_q};
        end
        else
        begin
          r_valid <= 1'b0;
          r_data <= ~r_data;
        end
        if (r_valid && r_last)
          busy_q <= 1'b0;
      end
    end
  end
endmodule

// ### tb/l2pf_prefetch_linefill_bench.sv
// self-checking bench for the prefetch and linefill block
`timescale 1ns/1ns
`include "l2pf_defs.vh"
module l2pf_prefetch_linefill_bench;
  reg clk_sys, arst_n, reg_wr, reg_rd, sp_valid, sp_cacheable, miss_valid, lookup_done, lookup_hit, slow, lk_hit;
  reg excl;
  reg [7:0] reg_addr;
  reg [31:0] reg_wdata, sp_addr, miss_addr, cfg, x;
  reg [1:0] miss_burst;
  reg [3:0] miss_len;
  reg [2:0] miss_size;
  wire miss_ready, lookup_valid, ar_valid, ar_ready, r_valid, r_ready, r_last;
  wire fill_valid, fill_alloc, fill_prefetch, fill_last;
  wire [31:0] reg_rdata, lookup_addr, ar_addr, fill_addr;
  wire [3:0] ar_len;
  wire [1:0] ar_burst;
  wire [2:0] ar_size;
  wire [63:0] r_data, fill_data;
  integer err_count, check_count, seed, cyc, i, lk_cnt;
  reg [66:0] lq[$];
  reg [66:0] fq[$];
  l2pf_prefetch_linefill i_l2pf_prefetch_linefill (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sp_valid, .sp_cacheable, .sp_addr, .miss_valid, .miss_ready, .miss_addr, .miss_burst,
    .miss_len, .miss_size, .lookup_valid, .lookup_addr, .lookup_done, .lookup_hit, .ar_valid, .ar_ready,
    .ar_addr, .ar_len, .ar_burst, .ar_size, .r_valid, .r_ready, .r_data, .r_last, .fill_valid, .fill_addr,
    .fill_data, .fill_alloc, .fill_prefetch, .fill_last);
  l2pf_l3_model i_l2pf_l3_model (.clk_sys, .arst_n, .slow, .ar_valid, .ar_ready, .ar_addr, .ar_len,
    .r_valid, .r_ready, .r_data, .r_last);
  task print_verdict;
  begin
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  task chk(input [66:0] got, input [66:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
  begin
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  end
  endtask
  task rd(input [7:0] a, input [31:0] d);
  begin
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, d);
    @(posedge clk_sys);
  end
  endtask
  // expected burst worked out from the control bits, then every beat compared
  task run(input [31:0] a, input [1:0] b, input [3:0] l, input [2:0] s, input pf);
    reg [31:0] ea, ln, t;
    reg [1:0] eb;
    reg [3:0] el;
    integer j;
  begin
    {ea, eb, el} = {a, 2'h2, 4'h3};
    ln = a & 32'hFFFFFFE0;
    if (cfg[30] && (b[0] ^ b[1]) && l == 4'h3 && s == 3'h3 && !(pf && excl) && !(a[4:0] != 5'h0 && cfg[27]))
    begin
      if (!(a[5] && cfg[23]))
        {ea, eb, el} = {ln, 2'h2, 4'h7};
      else if (a[11:5] != 7'h7F)
        {ea, eb, el} = {ln, 2'h1, 4'h7};
    end
    if (!pf)
    begin
      {miss_valid, miss_addr, miss_burst, miss_len, miss_size} <= {1'b1, a, b, l, s};
      @(posedge clk_sys);
      while (!miss_ready) @(posedge clk_sys);
      miss_valid <= 1'b0;
    end
    while (!(ar_valid && ar_ready)) @(posedge clk_sys);
    chk({ar_addr, ar_burst, ar_len}, {ea, eb, el});
    if (pf)
      chk(lq.pop_front(), a);
    while (fq.size() <= el) @(posedge clk_sys);
    if (el == 4'h7)
      chk(lq.pop_front(), eb == 2'h1 ? ea + 32'h20 : ea ^ 32'h20);
    for (j = 0; j <= el; j = j + 1)
    begin
      t = el == 4'h7 ? 32'h3F : 32'h1F;
      t = eb == 2'h1 ? ea + j * 8 : (ea & ~t) | ((ea + j * 8) & t);
      chk(fq.pop_front(), {j < 4 || !lk_hit, pf, j == el, t, ea});
    end
  end
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == 30000)
    begin
      err_count = err_count + 1;
      print_verdict;
    end
    lookup_done <= 1'b0;
    if (fill_valid)
      fq.push_back({fill_alloc, fill_prefetch, fill_last, fill_addr, fill_data[63:32]});
    if (lookup_valid && !lookup_done)
    begin
      lk_cnt = lk_cnt + 1;
      if (lk_cnt > 2)
      begin
        {lookup_done, lookup_hit} <= {1'b1, lk_hit};
        lk_cnt = 0;
        lq.push_back(lookup_addr);
      end
    end
  end
  initial
  begin
    {arst_n, reg_wr, reg_rd, sp_valid, sp_cacheable, miss_valid, lookup_done, lookup_hit, slow, lk_hit, excl} = '0;
    {reg_addr, reg_wdata, sp_addr, miss_addr, miss_burst, miss_len, miss_size, cfg} = '0;
    {err_count, check_count, cyc, lk_cnt} = '0;
    seed = 32'h305D;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rd(`L2PF_OFS_PF_CTRL, `L2PF_PF_CTRL_RST);
    wr(`L2PF_OFS_PF_CTRL, 32'hFFFFFFFF);
    rd(`L2PF_OFS_PF_CTRL, 32'h7880001F);
    rd(8'h10, 32'h0);
    // non-cacheable, engine off, page crossing: none may look up
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(`L2PF_OFS_PF_CTRL, i == 1 ? 32'h0 : 32'h10000000);
      {sp_valid, sp_cacheable, sp_addr} <= {1'b1, i != 0, i == 2 ? 32'h0FE0 : 32'h0100};
      @(posedge clk_sys);
      sp_valid <= 1'b0;
      repeat (20) @(posedge clk_sys);
      chk(lq.size(), 0);
    end
    for (i = 0; i < 48; i = i + 1)
    begin
      cfg = $random(seed) & 32'h48800000;
      wr(`L2PF_OFS_PF_CTRL, cfg);
      {slow, lk_hit} <= $random(seed);
      x = $random(seed) & 32'hFFFFFFF8;
      if (i % 5 == 0)
        x[11:5] = 7'h7F;
      run(x, i % 4 == 3 ? 2'h0 : 2'h1 + i[0], i % 8 == 5 ? 4'h1 : 4'h3, 3'h3, 1'b0);
    end
    for (i = 0; i < 8; i = i + 1)
    begin
      excl = i[2];
      wr(`L2PF_OFS_CFG, {31'h0, excl});
      cfg = ($random(seed) & 32'h4880001F) | (i[0] ? 32'h20000000 : 32'h10000000);
      lk_hit <= 1'b0;
      wr(`L2PF_OFS_PF_CTRL, cfg);
      x = ($random(seed) & 32'hFFFFF000) | 32'h108;
      {sp_valid, sp_cacheable, sp_addr} <= {2'h3, x};
      @(posedge clk_sys);
      sp_valid <= 1'b0;
      run(((x >> 5) + 1 + cfg[4:0]) << 5, 2'h2, 4'h3, 3'h3, 1'b1);
    end
    rd(`L2PF_OFS_PF_COUNT, 32'h00000008);
    print_verdict;
  end
endmodule

// ### tb/l2pf_sva.sv
// checker for the linefill request and fill ports
`timescale 1ns/1ns
module l2pf_sva (
  input wire clk_sys,
  input wire arst_n,
  input wire miss_valid,
  input wire miss_ready,
  input wire ar_valid,
  input wire ar_ready,
  input wire [31:0] ar_addr,
  input wire [3:0] ar_len,
  input wire [1:0] ar_burst,
  input wire [2:0] ar_size,
  input wire r_valid,
  input wire r_ready,
  input wire fill_valid,
  input wire lookup_valid,
  input wire lookup_done,
  input wire [31:0] lookup_addr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  property p_len;
    ar_valid |-> ar_size == 3'h3 && (ar_len == 4'h3 || ar_len == 4'h7);
  endproperty
  a_len: assert property (p_len) else $error("bad burst shape");
  property p_hold;
    ar_valid && !ar_ready |=> ar_valid && $stable(ar_addr) && $stable({ar_len, ar_burst});
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_take;
    miss_valid && miss_ready |=> ar_valid;
  endproperty
  a_take: assert property (p_take) else $error("miss not issued");
  property p_incr;
    ar_valid && ar_burst == 2'h1 |-> ar_len == 4'h7 && ar_addr[5:0] == 6'h20;
  endproperty
  a_incr: assert property (p_incr) else $error("bad incr fill");
  property p_wrap8;
    ar_valid && ar_burst == 2'h2 && ar_len == 4'h7 |-> ar_addr[4:0] == 5'h0;
  endproperty
  a_wrap8: assert property (p_wrap8) else $error("double fill not aligned");
  property p_page;
    ar_valid && ar_burst == 2'h1 |-> ar_addr[11:5] != 7'h7F;
  endproperty
  a_page: assert property (p_page) else $error("double fill crosses page");
  property p_beat;
    r_valid && r_ready |=> fill_valid;
  endproperty
  a_beat: assert property (p_beat) else $error("beat lost");
  property p_look;
    lookup_valid && !lookup_done |=> lookup_valid && $stable(lookup_addr);
  endproperty
  a_look: assert property (p_look) else $error("lookup dropped");
endmodule
bind l2pf_prefetch_linefill l2pf_sva i_l2pf_sva (.clk_sys, .arst_n, .miss_valid, .miss_ready, .ar_valid,
  .ar_ready, .ar_addr, .ar_len, .ar_burst, .ar_size, .r_valid, .r_ready, .fill_valid, .lookup_valid,
  .lookup_done, .lookup_addr);
